// ===== inc/rtca_pkg.sv
// Summary of operation
// - without chime, repeat count N gives N plus one events
// - every alarm event decrements a nonzero repeat count
// - zero wraps to FF only with chime
// - event at zero without chime clears enable
// - alarm control reset by power-on only
// - hours tens 29-28, units 27-24
// - minutes tens 22-20, units 19-16
// - seconds tens 14-12, units 11-8
// - unused time bits read zero
// - value writes need write enable set
// - years tens 31-28, units 27-24
// - month tens bit 20, units 19-16
// - day tens 13-12, units 11-8
// - weekday in 2-0, rest zero
package rtca_pkg;
    // byte offsets on the bus
    localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
    localparam logic [7:0] OFS_ALARM_CONTROL = 8'h04;
    localparam logic [7:0] OFS_TIME_VALUE    = 8'h08;
    localparam logic [7:0] OFS_DATE_VALUE    = 8'h0C;
    // clock_control bit positions
    localparam int CC_ON   = 15;
    localparam int CC_WREN = 3;
    localparam int CC_SYNC = 2;
    localparam int CC_HALF = 1;
    // alarm_control bit positions
    localparam int AC_EN    = 15;
    localparam int AC_CHIME = 14;
    localparam int AC_PIV   = 13;
    localparam int AC_SYNC  = 12;
    localparam int AC_MASK  = 8;
    localparam int AC_RPT   = 0;
    // repeat count end points
    localparam logic [7:0] RPT_ZERO = 8'h00;
    localparam logic [7:0] RPT_WRAP = 8'hFF;
    // time_value field positions
    localparam int T_HT = 28;
    localparam int T_HU = 24;
    localparam int T_MT = 20;
    localparam int T_MU = 16;
    localparam int T_ST = 12;
    localparam int T_SU = 8;
    // date_value field positions
    localparam int D_YT = 28;
    localparam int D_YU = 24;
    localparam int D_MT = 20;
    localparam int D_MU = 16;
    localparam int D_DT = 12;
    localparam int D_DU = 8;
    localparam int D_WD = 0;
    // timing: system clock and derived rtc tick
    localparam int SYS_CLK_HZ     = 20_000_000;
    localparam int RTC_CLK_HZ     = 32_768;
    localparam int RTC_DIV        = SYS_CLK_HZ / RTC_CLK_HZ;
    localparam int HALF_SEC_TICKS = RTC_CLK_HZ / 2;
    localparam int SYNC_TICKS     = 32;
    // time of day as packed bcd digits
    typedef struct packed {
        logic [1:0] hours_tens;
        logic [3:0] hours_units;
        logic [2:0] minutes_tens;
        logic [3:0] minutes_units;
        logic [2:0] seconds_tens;
        logic [3:0] seconds_units;
    } rtca_time_t;
    // calendar date as packed bcd digits
    typedef struct packed {
        logic [3:0] years_tens;
        logic [3:0] years_units;
        logic       months_tens;
        logic [3:0] months_units;
        logic [1:0] days_tens;
        logic [3:0] days_units;
        logic [2:0] weekday_value;
    } rtca_date_t;
endpackage

// ===== verilog/rtca_cal_step.sv
`timescale 1ns/1ns
// next calendar value one second on; pure logic
module rtca_cal_step (
    input  rtca_pkg::rtca_time_t cur_time_i,
    input  rtca_pkg::rtca_date_t cur_date_i,
    output rtca_pkg::rtca_time_t next_time_o,
    output rtca_pkg::rtca_date_t next_date_o
);
    import rtca_pkg::*;
    // two bcd digits to binary
    function automatic logic [6:0] bin(input logic [3:0] t,
                                       input logic [3:0] u);
        bin = 7'(t) * 7'd10 + 7'(u);
    endfunction
    logic [6:0] month_bin; // month as binary
    logic [6:0] day_bin;   // day as binary
    logic [6:0] last_day;  // length of this month
    logic       leap;      // year divisible by four
    // carry chain, seconds up to year
    always_comb begin
        next_time_o = cur_time_i;
        next_date_o = cur_date_i;
        month_bin = bin({3'h0, cur_date_i.months_tens},
                        cur_date_i.months_units);
        day_bin = bin({2'h0, cur_date_i.days_tens},
                      cur_date_i.days_units);
        // mod four from 2*tens + units
        leap = (cur_date_i.years_tens[0] == 1'b0) ?
               (cur_date_i.years_units inside {4'h0, 4'h4, 4'h8}) :
               (cur_date_i.years_units inside {4'h2, 4'h6});
        case (month_bin)
            7'd2:    last_day = leap ? 7'd29 : 7'd28;
            7'd4, 7'd6, 7'd9, 7'd11: last_day = 7'd30;
            default: last_day = 7'd31;
        endcase
        if (cur_time_i.seconds_units != 4'h9) begin
            next_time_o.seconds_units = cur_time_i.seconds_units + 4'h1;
        end else if (cur_time_i.seconds_tens != 3'h5) begin
            next_time_o.seconds_units = 4'h0;
            next_time_o.seconds_tens = cur_time_i.seconds_tens + 3'h1;
        end else begin
            next_time_o.seconds_units = 4'h0;
            next_time_o.seconds_tens = 3'h0;
            if (cur_time_i.minutes_units != 4'h9) begin
                next_time_o.minutes_units =
                    cur_time_i.minutes_units + 4'h1;
            end else if (cur_time_i.minutes_tens != 3'h5) begin
                next_time_o.minutes_units = 4'h0;
                next_time_o.minutes_tens = cur_time_i.minutes_tens + 3'h1;
            end else begin
                next_time_o.minutes_units = 4'h0;
                next_time_o.minutes_tens = 3'h0;
                if (cur_time_i.hours_tens == 2'h2 &&
                    cur_time_i.hours_units == 4'h3) begin
                    next_time_o.hours_tens = 2'h0;
                    next_time_o.hours_units = 4'h0;
                    // new day
                    next_date_o.weekday_value =
                        (cur_date_i.weekday_value == 3'h6) ? 3'h0 :
                        cur_date_i.weekday_value + 3'h1;
                    if (day_bin < last_day) begin
                        if (cur_date_i.days_units == 4'h9) begin
                            next_date_o.days_units = 4'h0;
                            next_date_o.days_tens =
                                cur_date_i.days_tens + 2'h1;
                        end else begin
                            next_date_o.days_units =
                                cur_date_i.days_units + 4'h1;
                        end
                    end else begin
                        next_date_o.days_tens = 2'h0;
                        next_date_o.days_units = 4'h1;
                        if (month_bin >= 7'd12) begin
                            next_date_o.months_tens = 1'b0;
                            next_date_o.months_units = 4'h1;
                            if (cur_date_i.years_units == 4'h9) begin
                                next_date_o.years_units = 4'h0;
                                next_date_o.years_tens =
                                    (cur_date_i.years_tens == 4'h9) ?
                                    4'h0 : cur_date_i.years_tens + 4'h1;
                            end else begin
                                next_date_o.years_units =
                                    cur_date_i.years_units + 4'h1;
                            end
                        end else if (cur_date_i.months_units == 4'h9) begin
                            next_date_o.months_units = 4'h0;
                            next_date_o.months_tens = 1'b1;
                        end else begin
                            next_date_o.months_units =
                                cur_date_i.months_units + 4'h1;
                        end
                    end
                end else if (cur_time_i.hours_units == 4'h9) begin
                    next_time_o.hours_units = 4'h0;
                    next_time_o.hours_tens = cur_time_i.hours_tens + 2'h1;
                end else begin
                    next_time_o.hours_units = cur_time_i.hours_units + 4'h1;
                end
            end
        end
    end
endmodule

// ===== verilog/rtca_top.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
// rtc value registers and alarm repeat counter behind apb
module rtca_top #(
    parameter int HALF_TICKS = rtca_pkg::HALF_SEC_TICKS
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        alarm_match_i,
    output logic             alarm_event_o,
    output logic             alarm_pulse_o,
    output logic             seconds_tick_o
);
    import rtca_pkg::*;

    // counter widths
    localparam int DW = $clog2(RTC_DIV);
    localparam int PW = $clog2(HALF_TICKS);
    localparam logic [DW-1:0] DIV_LAST = DW'(RTC_DIV - 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(HALF_TICKS - 1);
    localparam logic [PW-1:0] SYNC_FROM =
        PW'(HALF_TICKS - SYNC_TICKS);

    // bus decode
    logic        setup_ph;   // first cycle of a transfer
    logic        wr_acc;     // write taking effect now
    logic        hit_cc;     // clock_control selected
    logic        hit_ac;     // alarm_control selected
    logic        hit_tv;     // time_value selected
    logic        hit_dv;     // date_value selected
    logic        mapped;     // any register selected

    // clock_control state
    logic        clk_on;     // module running
    logic        value_write_enable; // unlocks value writes
    logic        half_sec;   // second half of a second

    // alarm_control state
    logic        alarm_enable;       // alarm armed
    logic        chime;              // repeat count may wrap
    logic        pulse_init;         // pulse start level
    logic [3:0]  alarm_mask;         // held for compare logic
    logic [7:0]  alarm_repeat_count; // events left minus one
    logic        alarm_sync_status;  // near half second edge

    // timebase
    logic [DW-1:0] div_cnt;  // system cycles per rtc tick
    logic [PW-1:0] pre_cnt;  // rtc ticks per half second
    logic          rtc_tick; // one cycle rtc clock enable
    logic          half_end; // last tick of a half second
    logic          sec_tick; // start of a new second

    // calendar values
    rtca_time_t  time_value;      // live time of day
    rtca_date_t  date_value;      // live date
    rtca_time_t  next_time_value; // one second later
    rtca_date_t  next_date_value; // one second later
    rtca_time_t  wr_time;         // bus data as time
    rtca_date_t  wr_date;         // bus data as date

    // alarm event
    logic        alarm_evt;  // qualified alarm match

    // readback
    logic [31:0] next_rdata; // word for the addressed reg

    // zero wait state slave, so pready is constant high
    assign pready_o = 1'b1;

    // setup phase captures the read word
    assign setup_ph = psel_i & ~penable_i;

    // writes land at the access edge only
    assign wr_acc = psel_i & penable_i & pwrite_i;

    // address decode on full byte address
    assign hit_cc = (paddr_i == OFS_CLOCK_CONTROL);
    assign hit_ac = (paddr_i == OFS_ALARM_CONTROL);
    assign hit_tv = (paddr_i == OFS_TIME_VALUE);
    assign hit_dv = (paddr_i == OFS_DATE_VALUE);
    assign mapped = hit_cc | hit_ac | hit_tv | hit_dv;

    // bus word unpacked into digit fields
    always_comb begin
        wr_time.hours_tens    = pwdata_i[T_HT +: 2];
        wr_time.hours_units   = pwdata_i[T_HU +: 4];
        wr_time.minutes_tens  = pwdata_i[T_MT +: 3];
        wr_time.minutes_units = pwdata_i[T_MU +: 4];
        wr_time.seconds_tens  = pwdata_i[T_ST +: 3];
        wr_time.seconds_units = pwdata_i[T_SU +: 4];
        wr_date.years_tens    = pwdata_i[D_YT +: 4];
        wr_date.years_units   = pwdata_i[D_YU +: 4];
        wr_date.months_tens   = pwdata_i[D_MT];
        wr_date.months_units  = pwdata_i[D_MU +: 4];
        wr_date.days_tens     = pwdata_i[D_DT +: 2];
        wr_date.days_units    = pwdata_i[D_DU +: 4];
        wr_date.weekday_value = pwdata_i[D_WD +: 3];
    end

    // rtc clock enable from the system clock
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            div_cnt <= '0;
        end else if (!clk_on) begin
            // parked while off
            div_cnt <= '0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DW'(1);
        end
    end

    assign rtc_tick = clk_on & (div_cnt == DIV_LAST);
    assign half_end = rtc_tick & (pre_cnt == PRE_LAST);
    assign sec_tick = half_end & half_sec;

    // a seconds write restarts the prescaler
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pre_cnt <= '0;
        end else if (wr_acc && hit_tv && value_write_enable) begin
            pre_cnt <= '0;
        end else if (half_end) begin
            pre_cnt <= '0;
        end else if (rtc_tick) begin
            pre_cnt <= pre_cnt + PW'(1);
        end
    end

    // half second status, cleared by a seconds write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            half_sec <= 1'b0;
        end else if (wr_acc && hit_tv && value_write_enable) begin
            half_sec <= 1'b0;
        end else if (half_end) begin
            half_sec <= ~half_sec;
        end
    end

    // within 32 rtc ticks of a half second rollover;
    // software must keep off the repeat field then
    // and finish a read inside 32 rtc ticks
    assign alarm_sync_status =
        clk_on & (pre_cnt >= SYNC_FROM);

    // clock_control: power-on reset only
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            value_write_enable <= 1'b0;
        end else if (wr_acc && hit_cc) begin
            value_write_enable <= pwdata_i[CC_WREN];
        end
    end

    // the on bit shares the write lock
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clk_on <= 1'b0;
        end else if (wr_acc && hit_cc && value_write_enable) begin
            clk_on <= pwdata_i[CC_ON];
        end
    end

    // an alarm counts only while armed and running
    assign alarm_evt = alarm_match_i & alarm_enable & clk_on;

    // repeat count: hardware event beats a bus write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            alarm_repeat_count <= RPT_ZERO;
        end else if (alarm_evt) begin
            if (alarm_repeat_count != RPT_ZERO) begin
                // one event used up
                alarm_repeat_count <=
                    alarm_repeat_count - 8'h01;
            end else if (chime) begin
                // chime keeps the alarm going forever
                alarm_repeat_count <= RPT_WRAP;
            end
            // no chime: stays at zero
        end else if (wr_acc && hit_ac) begin
            alarm_repeat_count <= pwdata_i[AC_RPT +: 8];
        end
    end

    // alarm enable: auto clear after the last event
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            alarm_enable <= 1'b0;
        end else if (alarm_evt && !chime &&
                     alarm_repeat_count == RPT_ZERO) begin
            alarm_enable <= 1'b0;
        end else if (wr_acc && hit_ac) begin
            alarm_enable <= pwdata_i[AC_EN];
        end
    end

    // chime and mask are plain settings
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            chime      <= 1'b0;
            alarm_mask <= 4'h0;
        end else if (wr_acc && hit_ac) begin
            chime      <= pwdata_i[AC_CHIME];
            alarm_mask <= pwdata_i[AC_MASK +: 4];
        end
    end

    // pulse start level, locked while armed
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pulse_init <= 1'b0;
        end else if (wr_acc && hit_ac && !alarm_enable) begin
            pulse_init <= pwdata_i[AC_PIV];
        end
    end

    // alarm pulse toggles on each event
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            alarm_pulse_o <= 1'b0;
        end else if (!alarm_enable) begin
            // follows the start level while disarmed
            alarm_pulse_o <= pulse_init;
        end else if (alarm_evt) begin
            alarm_pulse_o <= ~alarm_pulse_o;
        end
    end

    // registered event and seconds strobes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            alarm_event_o  <= 1'b0;
            seconds_tick_o <= 1'b0;
        end else begin
            alarm_event_o  <= alarm_evt;
            seconds_tick_o <= sec_tick;
        end
    end

    // one second step of the calendar
    rtca_cal_step u_step (
        .cur_time_i  (time_value),
        .cur_date_i  (date_value),
        .next_time_o (next_time_value),
        .next_date_o (next_date_value)
    );

    // time: no reset, software sets it after power-up;
    // a locked write is dropped, a write beats a tick
    always_ff @(posedge clk_sys_i) begin
        if (wr_acc && hit_tv && value_write_enable) begin
            time_value <= wr_time;
        end else if (sec_tick) begin
            time_value <= next_time_value;
        end
    end

    // date: same lock and same priority as time
    always_ff @(posedge clk_sys_i) begin
        if (wr_acc && hit_dv && value_write_enable) begin
            date_value <= wr_date;
        end else if (sec_tick) begin
            date_value <= next_date_value;
        end
    end

    // read word, unused bits stay zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (1'b1)
            hit_cc: begin
                next_rdata[CC_ON]   = clk_on;
                next_rdata[CC_WREN] = value_write_enable;
                next_rdata[CC_SYNC] = alarm_sync_status;
                next_rdata[CC_HALF] = half_sec;
            end
            hit_ac: begin
                next_rdata[AC_EN]    = alarm_enable;
                next_rdata[AC_CHIME] = chime;
                // armed: pulse state, else start level
                next_rdata[AC_PIV]   = alarm_enable ?
                                       alarm_pulse_o : pulse_init;
                next_rdata[AC_SYNC]  = alarm_sync_status;
                next_rdata[AC_MASK +: 4] = alarm_mask;
                next_rdata[AC_RPT +: 8]  = alarm_repeat_count;
            end
            hit_tv: begin
                next_rdata[T_HT +: 2] = time_value.hours_tens;
                next_rdata[T_HU +: 4] = time_value.hours_units;
                next_rdata[T_MT +: 3] = time_value.minutes_tens;
                next_rdata[T_MU +: 4] = time_value.minutes_units;
                next_rdata[T_ST +: 3] = time_value.seconds_tens;
                next_rdata[T_SU +: 4] = time_value.seconds_units;
            end
            hit_dv: begin
                next_rdata[D_YT +: 4] = date_value.years_tens;
                next_rdata[D_YU +: 4] = date_value.years_units;
                next_rdata[D_MT]      = date_value.months_tens;
                next_rdata[D_MU +: 4] = date_value.months_units;
                next_rdata[D_DT +: 2] = date_value.days_tens;
                next_rdata[D_DU +: 4] = date_value.days_units;
                next_rdata[D_WD +: 3] = date_value.weekday_value;
            end
            default: begin
                // unmapped reads give zero
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data and error latched in setup phase,
    // so they are steady through the access cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (setup_ph) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
            pslverr_o <= ~mapped;
        end
    end
endmodule

// ===== verification/rtca_chk_sva.sv
`timescale 1ns/1ns
// port checks for the rtc alarm and value registers
module rtca_chk
    import rtca_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        alarm_match_i,
    input wire logic        alarm_event_o,
    input wire logic        alarm_pulse_o,
    input wire logic        seconds_tick_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // one read of an offset, ending in its access cycle
    sequence s_read(logic [7:0] a);
        psel_i && !penable_i && !pwrite_i && paddr_i == a
        ##1 psel_i && penable_i;
    endsequence
    rdy_const_a: assert property (pready_o)
        else $error("pready dropped");
    time_pad_a: assert property (
        s_read(OFS_TIME_VALUE) |-> (prdata_o & 32'hC08080FF) == 32'h0)
        else $error("time pad bits not zero");
    date_pad_a: assert property (
        s_read(OFS_DATE_VALUE) |-> (prdata_o & 32'h00E0C0F8) == 32'h0)
        else $error("date pad bits not zero");
    alarm_hi_a: assert property (
        s_read(OFS_ALARM_CONTROL) |-> prdata_o[31:16] == 16'h0)
        else $error("alarm upper half not zero");
    evt_cause_a: assert property (
        alarm_event_o |-> $past(alarm_match_i))
        else $error("alarm event without a match");
    evt_toggle_a: assert property (
        alarm_event_o |-> alarm_pulse_o != $past(alarm_pulse_o))
        else $error("alarm pulse did not toggle");
    tick_pulse_a: assert property (
        seconds_tick_o |=> !seconds_tick_o [*8])
        else $error("seconds tick too close");
    // own disable: this one watches the reset cycle itself
    por_clear_a: assert property (disable iff (1'b0)
        rst_i |=> !alarm_event_o && !seconds_tick_o && prdata_o == 32'h0)
        else $error("outputs not cleared by reset");
endmodule
bind rtca_top rtca_chk u_chk (
    .clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .alarm_match_i,
    .alarm_event_o, .alarm_pulse_o, .seconds_tick_o
);

// ===== verification/tb_rtca_top.sv
`timescale 1ns/1ns
// self-checking bench; short half second keeps the run small
module tb_rtca_top;
    import rtca_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        alarm_match_i = 1'b0;
    wire  [31:0] prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire         alarm_event_o;
    wire         alarm_pulse_o;
    wire         seconds_tick_o;
    int          errors = 0;
    int          n_compared = 0;
    logic        last_err;       // error flag of the last transfer
    logic [31:0] rd;             // data of the last read
    rtca_top #(.HALF_TICKS(40)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .alarm_match_i(alarm_match_i),
        .alarm_event_o(alarm_event_o), .alarm_pulse_o(alarm_pulse_o),
        .seconds_tick_o(seconds_tick_o)
    );
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            give_verdict();
        end
        rd = prdata_o;
        last_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // alarm writes wait for the quiet part of the half second
    task automatic wr_alarm(input logic [31:0] d);
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_ALARM_CONTROL, 32'h0);
            n++;
        end while (rd[AC_SYNC] !== 1'b0 && n < 9000);
        if (n >= 9000) begin
            errors++;
            give_verdict();
        end
        apb(1'b1, OFS_ALARM_CONTROL, d);
    endtask
    // one match cycle, then look at the event and pulse outputs;
    // the pulse bit of exp is the pulse level expected after it
    task automatic hit(input logic ev, input logic [31:0] exp);
        @(posedge clk_sys_i);
        alarm_match_i <= 1'b1;
        @(posedge clk_sys_i);
        alarm_match_i <= 1'b0;
        #1;
        chk({31'h0, alarm_event_o}, {31'h0, ev});
        chk({31'h0, alarm_pulse_o}, {31'h0, exp[AC_PIV]});
        apb(1'b0, OFS_ALARM_CONTROL, 32'h0);
        chk(rd & 32'h0000E0FF, exp);
    endtask
    task automatic t_reset();
        apb(1'b0, OFS_ALARM_CONTROL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], last_err}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_values();
        apb(1'b1, OFS_CLOCK_CONTROL, 32'h00000008);
        apb(1'b0, OFS_CLOCK_CONTROL, 32'h0);
        chk(rd, 32'h00000008);
        apb(1'b1, OFS_TIME_VALUE, 32'hE3D9D9FF);
        apb(1'b0, OFS_TIME_VALUE, 32'h0);
        chk(rd, 32'h23595900);
        apb(1'b1, OFS_DATE_VALUE, 32'h99F2F1FE);
        apb(1'b0, OFS_DATE_VALUE, 32'h0);
        chk(rd, 32'h99123106);
        apb(1'b1, OFS_CLOCK_CONTROL, 32'h0);
        apb(1'b1, OFS_TIME_VALUE, 32'h01020300);
        apb(1'b0, OFS_TIME_VALUE, 32'h0);
        chk(rd, 32'h23595900);
        $display("test values done");
    endtask
    task automatic t_calendar();
        int n;
        apb(1'b1, OFS_CLOCK_CONTROL, 32'h00000008);
        apb(1'b1, OFS_CLOCK_CONTROL, 32'h00008008);
        apb(1'b1, OFS_TIME_VALUE, 32'h23595900);
        n = 0;
        while (seconds_tick_o !== 1'b1 && n < 60000) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk(n < 60000, 32'h1);
        if (n >= 60000) begin
            give_verdict();
        end
        apb(1'b0, OFS_TIME_VALUE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_DATE_VALUE, 32'h0);
        chk(rd, 32'h00010100);
        // just past the second: running, first half, not near rollover
        apb(1'b0, OFS_CLOCK_CONTROL, 32'h0);
        chk(rd, 32'h00008008);
        $display("test calendar done");
    endtask
    task automatic t_alarm();
        wr_alarm(32'h00008001);
        hit(1'b1, 32'h0000A000);
        hit(1'b1, 32'h0);
        hit(1'b0, 32'h0);
        wr_alarm(32'h0000C000);
        hit(1'b1, 32'h0000E0FF);
        hit(1'b1, 32'h0000C0FE);
        $display("test alarm done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_values();
        t_calendar();
        t_alarm();
        give_verdict();
    end
endmodule
